// ---- core/pafo_regs.svh ----
// pin positions, thresholds and reset values for the port override block
`ifndef PAFO_REGS_SVH
`define PAFO_REGS_SVH

// port b pin positions
`define PAFO_B_SCK       3'd7
`define PAFO_B_MISO      3'd6
`define PAFO_B_MOSI      3'd5
`define PAFO_B_SS        3'd4
`define PAFO_B_AIN_MINUS 3'd3
`define PAFO_B_AIN_PLUS  3'd2
`define PAFO_B_CNT1      3'd1
`define PAFO_B_CNT0      3'd0

// port d pin positions inside the 3-bit d slice (pins 7..5)
`define PAFO_D_RD        2'd2
`define PAFO_D_WR        2'd1
`define PAFO_D_CMP1A     2'd0

// address mask thresholds: pin c[i] carries its address bit while mask < threshold
`define PAFO_MASK_THR_C7 3'h1
`define PAFO_MASK_THR_C6 3'h2
`define PAFO_MASK_THR_C5 3'h3
`define PAFO_MASK_THR_C4 3'h4
`define PAFO_MASK_THR_C3 3'h5
`define PAFO_MASK_THR_C2 3'h6
`define PAFO_MASK_THR_C1 3'h7
`define PAFO_MASK_THR_C0 3'h7

// reset values
`define PAFO_RST_BYTE    8'h00
`define PAFO_RST_BIT     1'b0

`endif

// ---- core/pafo_pkg.sv ----
// types shared by the port override block
package pafo_pkg;

   // override bundle for one pin
   typedef struct packed {
      logic pull_override_en;
      logic pull_override_val;
      logic dir_override_en;
      logic dir_override_val;
      logic value_override_en;
      logic value_override_val;
   } pafo_ovr_t;

   // resolved pad drive for one pin
   typedef struct packed {
      logic pull_up;
      logic oe;
      logic out;
   } pafo_pad_t;

   // spi unit side signals
   typedef struct packed {
      logic spi_unit_on;
      logic spi_controller_select;
      logic sck_out;
      logic slave_out;
      logic master_out;
   } pafo_spi_t;

   // values steered to the on-chip units
   typedef struct packed {
      logic sck_in;
      logic master_in;
      logic slave_in;
      logic ss_level;
      logic ss_active;
      logic counter0_source_pin;
      logic counter1_source_pin;
      logic [1:0] analog_path;
   } pafo_unit_t;

endpackage

// ---- core/pafo_override.sv ----
// alternate function override for port b, port c and port d pins 7..5
`timescale 1ns/100ps
module pafo_override
#(
   parameter int PORT_W = 8
)
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  sys_rst_i,
   // port registers and global pull-up control
   input  wire logic [PORT_W-1:0]     portb_out_i,
   input  wire logic [PORT_W-1:0]     portb_dir_i,
   input  wire logic [PORT_W-1:0]     portc_out_i,
   input  wire logic [PORT_W-1:0]     portc_dir_i,
   input  wire logic [2:0]            portd_out_i,
   input  wire logic [2:0]            portd_dir_i,
   input  wire logic                  global_pullup_off_i,
   // pin levels
   input  wire logic [PORT_W-1:0]     portb_pin_i,
   // spi unit
   input  pafo_pkg::pafo_spi_t        spi_i,
   // timers
   input  wire logic                  compare0_en_i,
   input  wire logic                  compare0_val_i,
   input  wire logic                  compare1_a_en_i,
   input  wire logic                  compare1_a_val_i,
   // external memory interface
   input  wire logic                  ext_mem_enable_i,
   input  wire logic [2:0]            ext_addr_mask_i,
   input  wire logic [PORT_W-1:0]     ext_addr_hi_i,
   input  wire logic                  ext_rd_strobe_i,
   input  wire logic                  ext_wr_strobe_i,
   // pad drive
   output pafo_pkg::pafo_pad_t [PORT_W-1:0] portb_pad_o,
   output pafo_pkg::pafo_pad_t [PORT_W-1:0] portc_pad_o,
   output pafo_pkg::pafo_pad_t [2:0]        portd_pad_o,
   // values to the units
   output pafo_pkg::pafo_unit_t       unit_o
);
   import pafo_pkg::*;
`include "pafo_regs.svh"

   // pin positions and thresholds are fixed to an 8-bit port
   if (PORT_W != 8)
   begin : g_width_check
      $error("pafo_override: PORT_W must be 8");
   end

   // ****************************************************************
   // override resolution
   // ****************************************************************

   // register path pull-up only for an input pin with global pull-ups on
   function automatic pafo_pad_t resolve(input pafo_ovr_t ov, input logic out_bit,
                                         input logic dir_bit, input logic pull_off);
      pafo_pad_t p;
      p.pull_up = ov.pull_override_en  ? ov.pull_override_val
                                       : (out_bit & ~dir_bit & ~pull_off);
      p.oe      = ov.dir_override_en   ? ov.dir_override_val  : dir_bit;
      p.out     = ov.value_override_en ? ov.value_override_val : out_bit;
      return p;
   endfunction

   // external memory override pattern: output, no pull-up, drive a value
   function automatic pafo_ovr_t xmem_ovr(input logic en, input logic val);
      pafo_ovr_t o;
      o.pull_override_en   = en;
      o.pull_override_val  = 1'b0;
      o.dir_override_en    = en;
      o.dir_override_val   = 1'b1;
      o.value_override_en  = en;
      o.value_override_val = val;
      return o;
   endfunction

   localparam logic [2:0] MASK_THR [PORT_W] = '{`PAFO_MASK_THR_C7, `PAFO_MASK_THR_C6,
                                               `PAFO_MASK_THR_C5, `PAFO_MASK_THR_C4,
                                               `PAFO_MASK_THR_C3, `PAFO_MASK_THR_C2,
                                               `PAFO_MASK_THR_C1, `PAFO_MASK_THR_C0};

   // ****************************************************************
   // next values
   // ****************************************************************

   pafo_pad_t [PORT_W-1:0] portb_reg, portb_next;
   pafo_pad_t [PORT_W-1:0] portc_reg, portc_next;
   pafo_pad_t [2:0]        portd_reg, portd_next;
   pafo_unit_t             unit_reg,  unit_next;

   logic spi_slave;
   logic spi_master;
   // high during reset and one cycle after: checks skip the first load
   logic rst_d_reg;
   assign spi_slave  = spi_i.spi_unit_on & ~spi_i.spi_controller_select;
   assign spi_master = spi_i.spi_unit_on &  spi_i.spi_controller_select;

   always_comb
   begin
      pafo_ovr_t ovb [PORT_W];
      pafo_ovr_t ovc [PORT_W];
      pafo_ovr_t ovd [3];
      for (int i = 0; i < PORT_W; i++)
      begin
         ovb[i] = '0;
         ovc[i] = '0;
      end
      for (int i = 0; i < 3; i++)
         ovd[i] = '0;

      // slave mode forces sck, mosi, select to input; pull-up stays on output bit
      for (int i = 4; i < PORT_W; i++)
      begin
         ovb[i].pull_override_val = portb_out_i[i] & ~global_pullup_off_i;
         ovb[i].dir_override_val  = 1'b0;
      end
      ovb[`PAFO_B_SS].pull_override_en   = spi_slave;
      ovb[`PAFO_B_SS].dir_override_en    = spi_slave;
      ovb[`PAFO_B_SCK].pull_override_en  = spi_slave;
      ovb[`PAFO_B_SCK].dir_override_en   = spi_slave;
      ovb[`PAFO_B_SCK].value_override_en = spi_master;
      ovb[`PAFO_B_SCK].value_override_val = spi_i.sck_out;
      ovb[`PAFO_B_MOSI].pull_override_en  = spi_slave;
      ovb[`PAFO_B_MOSI].dir_override_en   = spi_slave;
      ovb[`PAFO_B_MOSI].value_override_en = spi_master;
      ovb[`PAFO_B_MOSI].value_override_val = spi_i.master_out;
      // data-in pin is input as master; as slave it carries slave out, direction from register
      ovb[`PAFO_B_MISO].pull_override_en  = spi_master;
      ovb[`PAFO_B_MISO].dir_override_en   = spi_master;
      ovb[`PAFO_B_MISO].value_override_en = spi_slave;
      ovb[`PAFO_B_MISO].value_override_val = spi_i.slave_out;

      // compare output and its pwm share one path; direction is software's
      ovb[`PAFO_B_CNT0].value_override_en  = compare0_en_i;
      ovb[`PAFO_B_CNT0].value_override_val = compare0_val_i;

      for (int i = 0; i < PORT_W; i++)
         ovc[i] = xmem_ovr(ext_mem_enable_i & (ext_addr_mask_i < MASK_THR[PORT_W-1-i]),
                           ext_addr_hi_i[i]);

      ovd[`PAFO_D_RD] = xmem_ovr(ext_mem_enable_i, ext_rd_strobe_i);
      ovd[`PAFO_D_WR] = xmem_ovr(ext_mem_enable_i, ext_wr_strobe_i);
      ovd[`PAFO_D_CMP1A].value_override_en  = compare1_a_en_i;
      ovd[`PAFO_D_CMP1A].value_override_val = compare1_a_val_i;

      for (int i = 0; i < PORT_W; i++)
      begin
         portb_next[i] = resolve(ovb[i], portb_out_i[i], portb_dir_i[i],
                                 global_pullup_off_i);
         portc_next[i] = resolve(ovc[i], portc_out_i[i], portc_dir_i[i],
                                 global_pullup_off_i);
      end
      for (int i = 0; i < 3; i++)
         portd_next[i] = resolve(ovd[i], portd_out_i[i], portd_dir_i[i],
                                 global_pullup_off_i);

      // unit inputs; comparator pins only mirrored, the analog path is outside
      unit_next.sck_in              = portb_pin_i[`PAFO_B_SCK];
      unit_next.master_in           = portb_pin_i[`PAFO_B_MISO];
      unit_next.slave_in            = portb_pin_i[`PAFO_B_MOSI];
      unit_next.ss_level            = portb_pin_i[`PAFO_B_SS];
      unit_next.ss_active           = spi_slave & ~portb_pin_i[`PAFO_B_SS];
      unit_next.counter0_source_pin = portb_pin_i[`PAFO_B_CNT0];
      unit_next.counter1_source_pin = portb_pin_i[`PAFO_B_CNT1];
      unit_next.analog_path         = {portb_pin_i[`PAFO_B_AIN_MINUS],
                                       portb_pin_i[`PAFO_B_AIN_PLUS]};
   end

   // ****************************************************************
   // registers
   // ****************************************************************

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         portb_reg <= '0;
         portc_reg <= '0;
         portd_reg <= '0;
         unit_reg  <= '0;
         rst_d_reg <= 1'b1;
      end
      else
      begin
         rst_d_reg <= 1'b0;
         portb_reg <= portb_next;
         portc_reg <= portc_next;
         portd_reg <= portd_next;
         unit_reg  <= unit_next;
      end
   end

   assign portb_pad_o = portb_reg;
   assign portc_pad_o = portc_reg;
   assign portd_pad_o = portd_reg;
   assign unit_o      = unit_reg;

   // ****************************************************************
   // checks
   // ****************************************************************

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i || rst_d_reg);

   chk_ss_forced_in: assert property (spi_slave |=> !portb_pad_o[4].oe)
      else $error("select pin not forced to input in slave mode");
   chk_ss_active_low: assert property (!sys_rst_i |=>
      unit_o.ss_active == $past(spi_slave & ~portb_pin_i[4]))
      else $error("spi activation does not follow select level");
   chk_ss_master_dir: assert property (spi_master |=> portb_pad_o[4].oe == $past(portb_dir_i[4]))
      else $error("select direction not from register as master");
   chk_ss_pull_kept: assert property (spi_slave |=>
      portb_pad_o[4].pull_up == $past(portb_out_i[4] & ~global_pullup_off_i))
      else $error("select pull-up lost its output bit control");
   chk_mosi_master_val: assert property (spi_master |=>
      portb_pad_o[5].out == $past(spi_i.master_out))
      else $error("master data out not on pin");
   chk_miso_slave_val: assert property (spi_slave |=>
      portb_pad_o[6].out == $past(spi_i.slave_out) && portb_pad_o[6].oe == $past(portb_dir_i[6]))
      else $error("slave data out path wrong");
   chk_cmp0_value: assert property (compare0_en_i |=> portb_pad_o[0].out == $past(compare0_val_i))
      else $error("compare output missing on bit 0");
   chk_c7_addr: assert property (ext_mem_enable_i && ext_addr_mask_i == 3'h0 |=>
      portc_pad_o[7].oe && portc_pad_o[7].out == $past(ext_addr_hi_i[7]) && !portc_pad_o[7].pull_up)
      else $error("address bit 15 not on pin c7");
   chk_c4_released: assert property (ext_mem_enable_i && ext_addr_mask_i == 3'h4 |=>
      portc_pad_o[4].oe == $past(portc_dir_i[4]))
      else $error("pin c4 still overridden at mask 4");
   chk_c0_mask7: assert property (ext_mem_enable_i && ext_addr_mask_i == 3'h7 |=>
      portc_pad_o[0].out == $past(portc_out_i[0]))
      else $error("pin c0 overridden at mask 7");
   chk_rd_strobe: assert property (ext_mem_enable_i |=>
      portd_pad_o[2].oe && portd_pad_o[2].out == $past(ext_rd_strobe_i))
      else $error("read strobe not on pin d7");
   chk_wr_strobe: assert property (ext_mem_enable_i |=>
      portd_pad_o[1].oe && !portd_pad_o[1].pull_up && portd_pad_o[1].out == $past(ext_wr_strobe_i))
      else $error("write strobe not on pin d6");
   chk_plain_port: assert property (!ext_mem_enable_i |=>
      portd_pad_o[2].oe == $past(portd_dir_i[2]) && portd_pad_o[2].out == $past(portd_out_i[2]))
      else $error("register value not applied without override");

   cov_spi_slave_sel: cover property (spi_slave ##1 unit_o.ss_active);
   cov_spi_master:    cover property (spi_master ##1 spi_master);
   cov_xmem_partial:  cover property (ext_mem_enable_i && ext_addr_mask_i == 3'h4);
   cov_cmp0_pwm:      cover property (compare0_en_i ##1 compare0_en_i);

endmodule

// ---- tb/pafo_partner.sv ----
// partner model: spi unit, timers, external memory unit and port b pin levels
`timescale 1ns/100ps
module pafo_partner
   import pafo_pkg::*;
(
   // clock
   input  wire logic                  clk_i,
   // pad drive seen at the pins
   input  pafo_pkg::pafo_pad_t [7:0]  portb_pad_i,
   // unit side
   output pafo_pkg::pafo_spi_t        spi_o,
   output logic                       compare0_en_o,
   output logic                       compare0_val_o,
   output logic                       compare1_a_en_o,
   output logic                       compare1_a_val_o,
   output logic [7:0]                 ext_addr_hi_o,
   output logic                       ext_rd_strobe_o,
   output logic                       ext_wr_strobe_o,
   // pin levels
   output logic [7:0]                 portb_pin_o
);
   integer      seed = 32'h9322;
   logic [31:0] r;

   initial
   begin
      spi_o = '0;
      {compare0_en_o, compare0_val_o, compare1_a_en_o, compare1_a_val_o} = 4'h0;
      {ext_addr_hi_o, ext_rd_strobe_o, ext_wr_strobe_o} = 10'h000;
      portb_pin_o = 8'h00;
   end

   always @(posedge clk_i)
   begin
      r = $random(seed);
      spi_o <= r[4:0];
      {compare0_en_o, compare0_val_o, compare1_a_en_o, compare1_a_val_o} <= r[8:5];
      ext_addr_hi_o <= r[16:9];
      {ext_rd_strobe_o, ext_wr_strobe_o} <= r[18:17];
      // released pin: pull-up wins, else an outside driver sets a fresh level
      for (int i = 0; i < 8; i++)
         portb_pin_o[i] <= portb_pad_i[i].oe ? portb_pad_i[i].out
                                             : (portb_pad_i[i].pull_up | r[20+i]);
   end
endmodule

// ---- tb/pafo_override_bench.sv ----
// self-checking bench for the port override block
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      n_compared++; \
      if ((g) !== (e)) \
      begin \
         fail_count++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
      end \
   end
module pafo_override_bench;
   import pafo_pkg::*;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic [7:0]       b_out = '0, b_dir = '0, c_out = '0, c_dir = '0;
   logic [2:0]       d_out = '0, d_dir = '0, mask = '0;
   logic             pull_off = 1'b0, ext = 1'b0;
   logic [7:0]       b_pin, addr;
   logic             c0_en, c0_val, c1_en, c1_val, rd, wr, slv, mst;
   pafo_spi_t        spi;
   pafo_pad_t [7:0]  b_pad, c_pad, exp_b, exp_c;
   pafo_pad_t [2:0]  d_pad, exp_d;
   pafo_unit_t       unit, exp_u;
   integer           seed = 32'h9322;
   int               cyc = 0;
   int               fail_count = 0;
   int               n_compared = 0;

   initial
   begin
      forever #12.5 clk = ~clk;
   end

   pafo_override pafo_override_inst (.clk_i(clk), .sys_rst_i(rst), .portb_out_i(b_out),
      .portb_dir_i(b_dir), .portc_out_i(c_out), .portc_dir_i(c_dir), .portd_out_i(d_out),
      .portd_dir_i(d_dir), .global_pullup_off_i(pull_off), .portb_pin_i(b_pin), .spi_i(spi),
      .compare0_en_i(c0_en), .compare0_val_i(c0_val), .compare1_a_en_i(c1_en),
      .compare1_a_val_i(c1_val), .ext_mem_enable_i(ext), .ext_addr_mask_i(mask),
      .ext_addr_hi_i(addr), .ext_rd_strobe_i(rd), .ext_wr_strobe_i(wr),
      .portb_pad_o(b_pad), .portc_pad_o(c_pad), .portd_pad_o(d_pad), .unit_o(unit));

   pafo_partner pafo_partner_inst (.clk_i(clk), .portb_pad_i(b_pad), .spi_o(spi),
      .compare0_en_o(c0_en), .compare0_val_o(c0_val), .compare1_a_en_o(c1_en),
      .compare1_a_val_o(c1_val), .ext_addr_hi_o(addr), .ext_rd_strobe_o(rd),
      .ext_wr_strobe_o(wr), .portb_pin_o(b_pin));

   // ************************************
   // stimulus: random registers, a second reset mid-run
   // ************************************
   always @(posedge clk)
   begin
      logic [31:0] r;
      logic [7:0]  bo, bd;
      logic [2:0]  dd;
      r = $random(seed);
      bo = r[7:0];
      bd = r[15:8];
      dd = r[18:16];
      // later half of each span behaves like careful software
      if (cyc % 512 >= 256)
      begin
         bo[3:2] = 2'b00;
         bd[3:2] = 2'b00;
         bd[0] = 1'b1;
         dd[0] = 1'b1;
      end
      cyc <= cyc + 1;
      rst <= (cyc < 3) || (cyc >= 1000 && cyc < 1002);
      b_out <= bo;
      b_dir <= bd;
      d_dir <= dd;
      d_out <= r[21:19];
      mask <= r[24:22];
      ext <= r[26:25] != 2'b00;
      pull_off <= r[27];
      r = $random(seed);
      c_out <= r[7:0];
      c_dir <= r[15:8];
   end

   // ************************************
   // reference model, one cycle behind the inputs
   // ************************************
   always @(posedge clk)
   begin
      slv = spi.spi_unit_on & ~spi.spi_controller_select;
      mst = spi.spi_unit_on & spi.spi_controller_select;
      for (int i = 0; i < 8; i++)
      begin
         exp_b[i] = '{b_out[i] & ~b_dir[i] & ~pull_off, b_dir[i], b_out[i]};
         exp_c[i] = '{c_out[i] & ~c_dir[i] & ~pull_off, c_dir[i], c_out[i]};
         if (ext && int'(mask) < ((i == 0) ? 7 : 8 - i))
            exp_c[i] = '{1'b0, 1'b1, addr[i]};
      end
      for (int j = 0; j < 3; j++)
         exp_d[j] = '{d_out[j] & ~d_dir[j] & ~pull_off, d_dir[j], d_out[j]};
      if (mst)
      begin
         exp_b[6] = '{b_out[6] & ~pull_off, 1'b0, b_out[6]};
         exp_b[7].out = spi.sck_out;
         exp_b[5].out = spi.master_out;
      end
      if (slv)
      begin
         for (int k = 4; k < 8; k++)
            if (k != 6)
               exp_b[k] = '{b_out[k] & ~pull_off, 1'b0, b_out[k]};
         exp_b[6].out = spi.slave_out;
      end
      if (c0_en)
         exp_b[0].out = c0_val;
      if (ext)
      begin
         exp_d[2] = '{1'b0, 1'b1, rd};
         exp_d[1] = '{1'b0, 1'b1, wr};
      end
      if (c1_en)
         exp_d[0].out = c1_val;
      exp_u = '{b_pin[7], b_pin[6], b_pin[5], b_pin[4], slv & ~b_pin[4],
                b_pin[0], b_pin[1], b_pin[3:2]};
      if (rst)
      begin
         {exp_b, exp_c, exp_d, exp_u} = '0;
      end
   end

   initial
   begin
      @(posedge clk);
      forever
      begin
         @(negedge clk);
         `CHK("port b upper", exp_b[7:4], b_pad[7:4])
         `CHK("port b lower", exp_b[3:0], b_pad[3:0])
         `CHK("port c", exp_c, c_pad)
         `CHK("port d strobes", exp_d[2:1], d_pad[2:1])
         `CHK("port d compare", exp_d[0], d_pad[0])
         `CHK("unit values", exp_u, unit)
      end
   end

   task automatic final_report();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      wait (cyc == 2000);
      final_report();
   end

   // watchdog: the run needs 2000 cycles
   initial
   begin
      #(25 * 3000);
      fail_count++;
      final_report();
   end
endmodule
